// ### sctp_pkg.sv
/*
 * shared constants, types and helpers of the serial config test port:
 * instruction codes, data register widths, port states, pin carrier.
 * assumes nothing beyond a systemverilog-2012 compiler.
 */
package sctp_pkg;

    // instruction register and data register lengths
    localparam int IR_W = 6;
    localparam int ID_W = 32;
    localparam int PLD_ADDR_W = 75;
    localparam int PLD_DATA_W = 81;
    localparam int CFG_ADDR_W = 4;
    localparam int CFG_DATA_W = 41;
    localparam int STATUS_W = 12;
    localparam int UES_W = 16;

    // array depths of the stored cells
    localparam int PLD_DEPTH = 8;
    localparam int PLD_IDX_W = 3;
    localparam int CFG_DEPTH = 16;

    // helper saturation count for five tms-high edges
    localparam logic [2:0] TLR_ONES = 3'h5;

    typedef logic [IR_W-1:0] sctp_ir_t;

    // instruction codes
    localparam sctp_ir_t INS_EXTEST = 6'h00;
    localparam sctp_ir_t INS_ADDPLD = 6'h01;
    localparam sctp_ir_t INS_DATAPLD = 6'h02;
    localparam sctp_ir_t INS_ERASEAND = 6'h03;
    localparam sctp_ir_t INS_ERASEARCH = 6'h04;
    localparam sctp_ir_t INS_PROGPLD = 6'h05;
    localparam sctp_ir_t INS_PROGESF = 6'h06;
    localparam sctp_ir_t INS_BYPASS = 6'h07;
    localparam sctp_ir_t INS_READPLD = 6'h08;
    localparam sctp_ir_t INS_DISCHARGE = 6'h09;
    localparam sctp_ir_t INS_ADDCFG = 6'h0a;
    localparam sctp_ir_t INS_DATACFG = 6'h0b;
    localparam sctp_ir_t INS_ERASECFG = 6'h0c;
    localparam sctp_ir_t INS_PROGCFG = 6'h0d;
    localparam sctp_ir_t INS_READCFG = 6'h0e;
    localparam sctp_ir_t INS_CFGBE = 6'h16;
    localparam sctp_ir_t INS_SAFESTATE = 6'h17;
    localparam sctp_ir_t INS_PROGRAMEN = 6'h18;
    localparam sctp_ir_t INS_IDCODE = 6'h19;
    localparam sctp_ir_t INS_PROGRAMDIS = 6'h1a;
    localparam sctp_ir_t INS_ADDSTATUS = 6'h1b;
    localparam sctp_ir_t INS_SAMPLE = 6'h1c;
    localparam sctp_ir_t INS_ERASEUES = 6'h1d;
    localparam sctp_ir_t INS_SHIFTUES = 6'h1e;
    localparam sctp_ir_t INS_PROGUES = 6'h1f;

    // output reset values
    localparam logic TDO_RST = 1'b0;
    localparam logic TDO_OE_B_RST = 1'b1;

    // port states, gray coded along capture-shift-exit-pause-update
    typedef enum logic [3:0] {
        ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SELDR = 4'h3, ST_CAPDR = 4'h2,
        ST_SHDR = 4'h6, ST_EX1DR = 4'h7, ST_PADR = 4'h5, ST_EX2DR = 4'h4,
        ST_UPDR = 4'hc, ST_SELIR = 4'hd, ST_CAPIR = 4'hf, ST_SHIR = 4'he,
        ST_EX1IR = 4'ha, ST_PAIR = 4'hb, ST_EX2IR = 4'h9, ST_UPIR = 4'h8
    } sctp_state_e;

    // data register selected by the held instruction
    typedef enum logic [2:0] {
        SEL_BYP, SEL_ID, SEL_PADDR, SEL_PDATA,
        SEL_CADDR, SEL_CDATA, SEL_STAT, SEL_UES
    } sctp_sel_e;

    // pins of the test port as they arrive
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } sctp_pins_s;

    // next port state from the tms level at a rising test clock
    function automatic sctp_state_e sctp_next(sctp_state_e s, logic tms);
        case (s)
            ST_TLR: sctp_next = tms ? ST_TLR : ST_RTI;
            ST_RTI: sctp_next = tms ? ST_SELDR : ST_RTI;
            ST_SELDR: sctp_next = tms ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: sctp_next = tms ? ST_EX1DR : ST_SHDR;
            ST_SHDR: sctp_next = tms ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: sctp_next = tms ? ST_UPDR : ST_PADR;
            ST_PADR: sctp_next = tms ? ST_EX2DR : ST_PADR;
            ST_EX2DR: sctp_next = tms ? ST_UPDR : ST_SHDR;
            ST_UPDR: sctp_next = tms ? ST_SELDR : ST_RTI;
            ST_SELIR: sctp_next = tms ? ST_TLR : ST_CAPIR;
            ST_CAPIR: sctp_next = tms ? ST_EX1IR : ST_SHIR;
            ST_SHIR: sctp_next = tms ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: sctp_next = tms ? ST_UPIR : ST_PAIR;
            ST_PAIR: sctp_next = tms ? ST_EX2IR : ST_PAIR;
            ST_EX2IR: sctp_next = tms ? ST_UPIR : ST_SHIR;
            ST_UPIR: sctp_next = tms ? ST_SELDR : ST_RTI;
            default: sctp_next = ST_TLR;
        endcase
    endfunction

    // register path decode; every unlisted code lands on bypass
    function automatic sctp_sel_e sctp_select(sctp_ir_t ir);
        case (ir)
            INS_IDCODE: sctp_select = SEL_ID;
            INS_ADDPLD: sctp_select = SEL_PADDR;
            INS_DATAPLD, INS_READPLD, INS_PROGPLD: sctp_select = SEL_PDATA;
            INS_ADDCFG: sctp_select = SEL_CADDR;
            INS_DATACFG, INS_READCFG, INS_PROGCFG: sctp_select = SEL_CDATA;
            INS_ADDSTATUS: sctp_select = SEL_STAT;
            INS_SHIFTUES, INS_PROGUES: sctp_select = SEL_UES;
            default: sctp_select = SEL_BYP;
        endcase
    endfunction

endpackage

// ### sctp_sync.sv
/*
 * two-stage synchroniser for a vector of levels.
 * assumes every bit is a level that holds for several clk periods.
 */
module sctp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r; // first stage, read only by q

    // metastability filter; nothing but q looks at meta_r
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ### sctp_nvm.sv
/*
 * model of the stored configuration cells: one word write, bulk erase,
 * registered read of the addressed word.
 * assumes erase and write are one-cycle pulses that never coincide.
 */
module sctp_nvm #(
    parameter int W = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic erase,
    input wire logic wr_en,
    input wire logic [AW-1:0] addr,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem_r [DEPTH]; // cell array, erased state is zero

    // cells; reset stands for an erased part in simulation
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (erase) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (wr_en && (int'(addr) < DEPTH)) begin
            mem_r[addr] <= wdata;
        end
    end

    // read port, always tracking the address one cycle late
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (int'(addr) < DEPTH) begin
            rdata <= mem_r[addr];
        end else begin
            rdata <= '0;
        end
    end
endmodule

// ### sctp_top.sv
/*
 * serial config test port: port state machine, instruction register,
 * bypass, id, address, data, status and ues registers, program and
 * erase sequencing into the stored cells.
 * assumes clk runs at least four times faster than the test clock and
 * that the test pins and comparator levels are asynchronous to clk.
 */
// Notes on behaviour
// [RULE1] port serves programming only, no scan cells
// [RULE2] held instruction picks register and operation
// [RULE3] controller loads address, data, then program
// [RULE4] stored configuration shifts back out for verify
// [RULE5] bypass is one flip-flop, tdi to tdo
// [RULE6] scan-type instructions fall back to bypass
// [RULE7] identification register readable through the port
// [RULE8] six extra registers for cfg and logic
// [RULE9] status register shows twelve comparator outputs
// [RULE10] works as one member of chain
// [RULE11] system keeps this part on own chain
// [RULE12] instructions reach every register, erase, program
// [RULE13] instruction register is six bits wide
// [RULE14] sample on rising, drive tdo on falling
// [RULE15] instruction capture loads the id instruction
// [RULE16] comparator status register is twelve bits
// [RULE17] standard sixteen-state port sequence
module sctp_top
    import sctp_pkg::*;
#(
    parameter logic [sctp_pkg::ID_W-1:0] ID_VALUE = 32'h0a5a_5001 // arbitrary
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire sctp_pkg::sctp_pins_s pins,
    input wire logic [sctp_pkg::STATUS_W-1:0] cmp_in,
    output logic tdo,
    output logic tdo_oe_b,
    output logic safe_state,
    output logic program_mode
);
    import sctp_pkg::*;

    logic rst_meta_r; // reset release, first stage
    logic rst_sync_b; // reset used by the design
    sctp_pins_s pins_s; // synchronised pins
    logic [STATUS_W-1:0] cmp_s; // synchronised comparator levels
    logic tck_d_r; // delayed test clock for edge finding
    logic [2:0] warm_r; // ones shift in as the synchroniser fills
    logic rise; // test clock rising edge seen
    logic fall; // test clock falling edge seen
    sctp_state_e state_r; // port state
    sctp_ir_t ir_sh_r; // instruction shift stage
    sctp_ir_t ir_r; // held instruction
    sctp_ir_t ir_eff; // instruction in force when leaving update
    sctp_sel_e sel; // selected data path
    logic byp_r; // bypass stage
    logic [ID_W-1:0] id_sh_r;
    logic [PLD_ADDR_W-1:0] paddr_sh_r;
    logic [PLD_DATA_W-1:0] pdata_sh_r;
    logic [CFG_ADDR_W-1:0] caddr_sh_r;
    logic [CFG_DATA_W-1:0] cdata_sh_r;
    logic [STATUS_W-1:0] stat_sh_r;
    logic [UES_W-1:0] ues_sh_r;
    logic [UES_W-1:0] ues_r; // stored user signature
    logic [PLD_DATA_W-1:0] pld_rd; // stored pld word
    logic [CFG_DATA_W-1:0] cfg_rd; // stored cfg word
    logic dr_bit; // lsb of the selected data path
    logic go; // leaving update for run-test/idle
    logic esf_r; // security fuse, hides readback
    logic prog_pld_p_r, prog_cfg_p_r, erase_pld_p_r, erase_cfg_p_r;
    logic prog_ues_p_r, erase_ues_p_r, prog_esf_p_r;
    logic [2:0] ones_cnt_r; // helper: tms-high rising edges in a row

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_b <= rst_meta_r;
        end
    end

    sctp_sync #(.W(3)) u_pin_sync (
        .clk(clk),
        .rst_b(rst_sync_b),
        .d(pins),
        .q(pins_s)
    );

    sctp_sync #(.W(STATUS_W)) u_cmp_sync (
        .clk(clk),
        .rst_b(rst_sync_b),
        .d(cmp_in),
        .q(cmp_s)
    );

    // test clock edges, found on the synchronised copy only; ignored
    // until real pin levels arrive, else a parked-high tck fakes a rise
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tck_d_r <= 1'b0;
            warm_r <= '0;
        end else begin
            tck_d_r <= pins_s.tck;
            warm_r <= {warm_r[1:0], 1'b1};
        end
    end
    assign rise = warm_r[2] & pins_s.tck & ~tck_d_r;
    assign fall = warm_r[2] & ~pins_s.tck & tck_d_r;

    // port state machine, tms sampled at rising test clock
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_r <= ST_TLR;
        end else if (rise) begin
            state_r <= sctp_next(state_r, pins_s.tms); // [RULE17] [RULE14]
        end
    end

    // instruction shift stage: capture id code, shift lsb first
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ir_sh_r <= INS_IDCODE;
        end else if (rise && state_r == ST_CAPIR) begin
            ir_sh_r <= INS_IDCODE; // [RULE15]
        end else if (rise && state_r == ST_SHIR) begin
            ir_sh_r <= {pins_s.tdi, ir_sh_r[IR_W-1:1]}; // [RULE13]
        end
    end

    // held instruction; test-logic-reset falls back to id code
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ir_r <= INS_IDCODE;
        end else if (state_r == ST_TLR) begin
            ir_r <= INS_IDCODE;
        end else if (rise && state_r == ST_UPIR) begin
            ir_r <= ir_sh_r; // [RULE2]
        end
    end

    // no scan cells exist: scan codes and 1xxxxx decode to bypass
    assign sel = sctp_select(ir_r); // [RULE1] [RULE6] [RULE12]

    // bypass: single stage, zero on capture
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            byp_r <= 1'b0;
        end else if (rise && sel == SEL_BYP) begin
            if (state_r == ST_CAPDR) begin
                byp_r <= 1'b0;
            end else if (state_r == ST_SHDR) begin
                byp_r <= pins_s.tdi; // [RULE5]
            end
        end
    end

    // identification and status paths: capture then shift
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            id_sh_r <= '0;
            stat_sh_r <= '0;
        end else if (rise && state_r == ST_CAPDR) begin
            if (sel == SEL_ID) begin
                id_sh_r <= ID_VALUE; // [RULE7]
            end
            if (sel == SEL_STAT) begin
                stat_sh_r <= cmp_s; // [RULE9] [RULE16]
            end
        end else if (rise && state_r == ST_SHDR) begin
            if (sel == SEL_ID) begin
                id_sh_r <= {pins_s.tdi, id_sh_r[ID_W-1:1]};
            end
            if (sel == SEL_STAT) begin
                stat_sh_r <= {pins_s.tdi, stat_sh_r[STATUS_W-1:1]};
            end
        end
    end

    // address registers keep their contents through capture
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            paddr_sh_r <= '0;
            caddr_sh_r <= '0;
        end else if (rise && state_r == ST_SHDR) begin
            if (sel == SEL_PADDR) begin
                paddr_sh_r <= {pins_s.tdi, paddr_sh_r[PLD_ADDR_W-1:1]}; // [RULE8]
            end
            if (sel == SEL_CADDR) begin
                caddr_sh_r <= {pins_s.tdi, caddr_sh_r[CFG_ADDR_W-1:1]}; // [RULE8]
            end
        end
    end

    // data registers; read instructions capture stored cells
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pdata_sh_r <= '0;
            cdata_sh_r <= '0;
            ues_sh_r <= '0;
        end else if (rise && state_r == ST_CAPDR) begin
            if (ir_r == INS_READPLD) begin
                pdata_sh_r <= esf_r ? '0 : pld_rd; // [RULE4]
            end
            if (ir_r == INS_READCFG) begin
                cdata_sh_r <= esf_r ? '0 : cfg_rd; // [RULE4]
            end
            if (ir_r == INS_SHIFTUES) begin
                ues_sh_r <= ues_r;
            end
        end else if (rise && state_r == ST_SHDR) begin
            if (sel == SEL_PDATA) begin
                pdata_sh_r <= {pins_s.tdi, pdata_sh_r[PLD_DATA_W-1:1]};
            end
            if (sel == SEL_CDATA) begin
                cdata_sh_r <= {pins_s.tdi, cdata_sh_r[CFG_DATA_W-1:1]};
            end
            if (sel == SEL_UES) begin
                ues_sh_r <= {pins_s.tdi, ues_sh_r[UES_W-1:1]};
            end
        end
    end

    // lsb of the path that is being shifted
    always_comb begin
        case (sel)
            SEL_ID: dr_bit = id_sh_r[0];
            SEL_PADDR: dr_bit = paddr_sh_r[0];
            SEL_PDATA: dr_bit = pdata_sh_r[0];
            SEL_CADDR: dr_bit = caddr_sh_r[0];
            SEL_CDATA: dr_bit = cdata_sh_r[0];
            SEL_STAT: dr_bit = stat_sh_r[0];
            SEL_UES: dr_bit = ues_sh_r[0];
            default: dr_bit = byp_r;
        endcase
    end

    // tdo changes on falling edges only, released outside shifts
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tdo <= TDO_RST;
            tdo_oe_b <= TDO_OE_B_RST;
        end else if (fall) begin
            if (state_r == ST_SHDR) begin
                tdo <= dr_bit; // [RULE14]
                tdo_oe_b <= 1'b0;
            end else if (state_r == ST_SHIR) begin
                tdo <= ir_sh_r[0];
                tdo_oe_b <= 1'b0;
            end else begin
                tdo_oe_b <= 1'b1; // [RULE10] chain neighbours may drive
            end
        end
    end

    // program and erase run on entry to run-test/idle
    assign go = rise && !pins_s.tms &&
                (state_r == ST_UPDR || state_r == ST_UPIR);
    assign ir_eff = (state_r == ST_UPIR) ? ir_sh_r : ir_r;

    // one-cycle operation pulses; only while program mode is on
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            prog_pld_p_r <= 1'b0;
            prog_cfg_p_r <= 1'b0;
            erase_pld_p_r <= 1'b0;
            erase_cfg_p_r <= 1'b0;
            prog_ues_p_r <= 1'b0;
            erase_ues_p_r <= 1'b0;
            prog_esf_p_r <= 1'b0;
        end else begin
            prog_pld_p_r <= go && program_mode && ir_eff == INS_PROGPLD; // [RULE12]
            prog_cfg_p_r <= go && program_mode && ir_eff == INS_PROGCFG;
            erase_pld_p_r <= go && program_mode &&
                (ir_eff == INS_ERASEAND || ir_eff == INS_ERASEARCH ||
                 ir_eff == INS_CFGBE);
            erase_cfg_p_r <= go && program_mode &&
                (ir_eff == INS_ERASECFG || ir_eff == INS_CFGBE);
            prog_ues_p_r <= go && program_mode && ir_eff == INS_PROGUES;
            erase_ues_p_r <= go && program_mode &&
                (ir_eff == INS_ERASEUES || ir_eff == INS_CFGBE);
            prog_esf_p_r <= go && program_mode && ir_eff == INS_PROGESF;
        end
    end

    // program mode and safe outputs act at update of the instruction
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            program_mode <= 1'b0;
            safe_state <= 1'b0;
        end else if (rise && state_r == ST_UPIR) begin
            if (ir_sh_r == INS_PROGRAMEN) begin
                program_mode <= 1'b1;
                safe_state <= 1'b1;
            end else if (ir_sh_r == INS_SAFESTATE) begin
                safe_state <= 1'b1;
            end else if (ir_sh_r == INS_PROGRAMDIS) begin
                program_mode <= 1'b0;
                safe_state <= 1'b0;
            end
        end
    end

    // user signature and security fuse; full erase clears both
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ues_r <= '0;
            esf_r <= 1'b0;
        end else begin
            if (erase_ues_p_r) begin
                ues_r <= '0;
            end else if (prog_ues_p_r) begin
                ues_r <= ues_sh_r;
            end
            if (erase_cfg_p_r && erase_pld_p_r) begin
                esf_r <= 1'b0;
            end else if (prog_esf_p_r) begin
                esf_r <= 1'b1;
            end
        end
    end

    // stored cells: address register picks the word, data commits
    sctp_nvm #(.W(PLD_DATA_W), .DEPTH(PLD_DEPTH), .AW(PLD_IDX_W)) u_pld (
        .clk(clk),
        .rst_b(rst_sync_b),
        .erase(erase_pld_p_r),
        .wr_en(prog_pld_p_r), // [RULE3]
        .addr(paddr_sh_r[PLD_IDX_W-1:0]),
        .wdata(pdata_sh_r),
        .rdata(pld_rd)
    );

    sctp_nvm #(.W(CFG_DATA_W), .DEPTH(CFG_DEPTH), .AW(CFG_ADDR_W)) u_cfg (
        .clk(clk),
        .rst_b(rst_sync_b),
        .erase(erase_cfg_p_r),
        .wr_en(prog_cfg_p_r), // [RULE3]
        .addr(caddr_sh_r),
        .wdata(cdata_sh_r),
        .rdata(cfg_rd)
    );

    // helper for the five-edge reset check
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ones_cnt_r <= '0;
        end else if (rise) begin
            if (!pins_s.tms) begin
                ones_cnt_r <= '0;
            end else if (ones_cnt_r != TLR_ONES) begin
                ones_cnt_r <= ones_cnt_r + 3'h1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_b);

    a_tms_reset: assert property (ones_cnt_r == TLR_ONES |-> state_r == ST_TLR) // [RULE17]
        else $error("five tms-high edges did not reach reset state");
    a_ir_capture: assert property (rise && state_r == ST_CAPIR |=> ir_sh_r == INS_IDCODE) // [RULE15]
        else $error("instruction capture did not load id code");
    a_ir_update: assert property (rise && state_r == ST_UPIR |=> ir_r == $past(ir_sh_r)) // [RULE2]
        else $error("held instruction not updated");
    a_bypass_stage: assert property (rise && state_r == ST_SHDR && sel == SEL_BYP |=> byp_r == $past(pins_s.tdi)) // [RULE5]
        else $error("bypass stage did not take tdi");
    a_scan_to_bypass: assert property (ir_r == INS_EXTEST || ir_r == INS_SAMPLE || ir_r[IR_W-1] |-> sel == SEL_BYP) // [RULE6]
        else $error("scan instruction not on bypass");
    a_id_capture: assert property (rise && state_r == ST_CAPDR && ir_r == INS_IDCODE |=> id_sh_r == ID_VALUE) // [RULE7]
        else $error("id register capture wrong");
    a_status_capture: assert property (rise && state_r == ST_CAPDR && ir_r == INS_ADDSTATUS |=> stat_sh_r == $past(cmp_s)) // [RULE9]
        else $error("status capture wrong");
    a_tdo_falling: assert property (fall && state_r == ST_SHDR |=> tdo == $past(dr_bit) && !tdo_oe_b) // [RULE14]
        else $error("tdo not driven on falling edge");
    a_tdo_steady: assert property (!fall |=> $stable(tdo)) // [RULE14]
        else $error("tdo moved off a falling edge");
    a_prog_commit: assert property (prog_pld_p_r |-> state_r == ST_RTI && ir_r == INS_PROGPLD) // [RULE3]
        else $error("pld program outside run-test/idle");
    a_pld_readback: assert property (rise && state_r == ST_CAPDR && ir_r == INS_READPLD && !esf_r |=> pdata_sh_r == $past(pld_rd)) // [RULE4]
        else $error("pld readback capture wrong");

    c_id_shift: cover property (rise && state_r == ST_SHDR && sel == SEL_ID);
    c_pld_program: cover property (prog_pld_p_r);
    c_cfg_readback: cover property (rise && state_r == ST_CAPDR && ir_r == INS_READCFG);
    c_status_read: cover property (rise && state_r == ST_CAPDR && sel == SEL_STAT);
endmodule

// ### sctp_ctl.sv
/* model of the scan controller that drives the test pins.
   assumes clk is the bench clock; one tck period is 8 clk. */
module sctp_ctl (
    input wire logic clk,
    input wire logic tdo,
    input wire logic tdo_oe_b,
    output sctp_pkg::sctp_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ns;
    import sctp_pkg::*;
    // tck parks high between frames, one device on the chain
    initial pins = 3'h4;
    // fall with new tms/tdi, rise 4 clk later, read tdo mid-high
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge clk);
        pins <= '{tck: 1'b0, tms: m, tdi: d};
        repeat (4) @(posedge clk);
        pins.tck <= 1'b1;
        repeat (2) @(posedge clk);
        q = tdo_oe_b ? ~tdo : tdo; // released pin reads inverted
        @(posedge clk);
    endtask
    // idle to idle scan, lsb first, ir path when ir is set
    task automatic scan(input logic ir, input int n,
                        input logic [127:0] din, output logic [127:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) begin
            step(1'b1, 1'b0, q);
        end
        step(1'b0, 1'b0, q); // capture next
        step(1'b0, 1'b0, q); // into shift
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q); // update
        step(1'b0, 1'b0, q); // back to idle
        @(posedge clk); // let the update edge settle
    endtask
endmodule

// ### sctp_top_test.sv
/* self-checking bench of the serial config test port.
   assumes the controller model drives the pins. */
module sctp_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import sctp_pkg::*;
    localparam logic [ID_W-1:0] ID_EXP = 32'h1234_5679; // arbitrary
    localparam logic [CFG_DATA_W-1:0] CW = 41'h1_2345_6789a;
    localparam logic [PLD_DATA_W-1:0] PW = 81'h1_0000_abcd_ef01_2345_6789;
    logic clk, rst_b, q;
    sctp_pins_s pins;
    logic [STATUS_W-1:0] cmp_in;
    logic tdo, tdo_oe_b, safe_state, program_mode;
    logic [127:0] got;
    sctp_ir_t codes[4] = '{INS_EXTEST, INS_SAMPLE, INS_BYPASS, 6'h3f};
    int miscompares, num_checks, cycles;
    sctp_top #(.ID_VALUE(ID_EXP)) sctp_top_i (.clk(clk), .rst_b(rst_b),
        .pins(pins), .cmp_in(cmp_in), .tdo(tdo), .tdo_oe_b(tdo_oe_b),
        .safe_state(safe_state), .program_mode(program_mode));
    sctp_ctl sctp_ctl_i (.clk(clk), .tdo(tdo), .tdo_oe_b(tdo_oe_b),
        .pins(pins));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input string what, input logic [127:0] seen,
                         input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic ir(input sctp_ir_t c);
        sctp_ctl_i.scan(1'b1, IR_W, 128'(c), got);
    endtask
    task automatic dr(input int n, input logic [127:0] d);
        sctp_ctl_i.scan(1'b0, n, d, got);
    endtask
    // hang guard, run needs well under this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic test_reset();
        check("tdo", tdo, 1'b0);
        check("tdo_oe_b", tdo_oe_b, 1'b1);
        check("safe", {safe_state, program_mode}, 2'h0);
        dr(ID_W, '0);
        check("idcode", got[31:0], ID_EXP);
        $display("done reset");
    endtask
    task automatic test_bypass();
        ir(INS_BYPASS);
        check("ir capture", got[5:0], INS_IDCODE);
        foreach (codes[k]) begin
            ir(codes[k]);
            dr(2, 128'h1);
            check("bypass", got[1:0], 2'h2);
        end
        repeat (5) sctp_ctl_i.step(1'b1, 1'b0, q);
        sctp_ctl_i.step(1'b0, 1'b0, q);
        dr(ID_W, '0);
        check("tms reset", got[31:0], ID_EXP);
        $display("done bypass");
    endtask
    task automatic test_status();
        ir(INS_ADDSTATUS);
        dr(STATUS_W, '0);
        check("status", got[11:0], 12'ha5c);
        $display("done status");
    endtask
    task automatic test_program();
        ir(INS_SAFESTATE);
        check("safe only", {safe_state, program_mode}, 2'h2);
        ir(INS_PROGRAMEN);
        check("enable", {safe_state, program_mode}, 2'h3);
        ir(INS_ADDCFG);
        dr(CFG_ADDR_W, 128'h3);
        ir(INS_DATACFG);
        dr(CFG_DATA_W, 128'(CW));
        ir(INS_PROGCFG);
        ir(INS_READCFG);
        dr(CFG_DATA_W, '0);
        check("cfg read", got[40:0], CW);
        ir(INS_ADDPLD);
        dr(PLD_ADDR_W, 128'h5);
        ir(INS_DATAPLD);
        dr(PLD_DATA_W, 128'(PW));
        ir(INS_PROGPLD);
        ir(INS_READPLD);
        dr(PLD_DATA_W, '0);
        check("pld read", got[80:0], PW);
        ir(INS_PROGESF);
        ir(INS_READCFG);
        dr(CFG_DATA_W, '0);
        check("fuse", got[40:0], 41'h0);
        ir(INS_PROGRAMDIS);
        check("disable", {safe_state, program_mode}, 2'h0);
        $display("done program");
    endtask
    initial begin
        rst_b = 1'b0;
        cmp_in = 12'ha5c;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        sctp_ctl_i.step(1'b0, 1'b0, q);
        test_reset();
        test_bypass();
        test_status();
        test_program();
        print_verdict();
    end
endmodule
